// ---- core/sscs_pkg.sv ----
// sscs_pkg: constants and types shared by the sync serial port core
// assumes byte addresses on a 32-bit classic wishbone bus
`default_nettype none
package sscs_pkg;
    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL = 12'h380;
    localparam logic [11:0] OFS_BAUD = 12'h384;
    localparam logic [11:0] OFS_TXB = 12'h388;
    localparam logic [11:0] OFS_RXB = 12'h38C;
    localparam logic [11:0] OFS_ISR = 12'h3A0;
    localparam logic [11:0] OFS_IMR = 12'h3A4;
    // ==========================================================
    // control / status bit positions
    localparam int B_EN = 15;
    localparam int B_MS = 14;
    localparam int B_BSY = 12;
    localparam int B_BEN = 11;
    localparam int B_PEN = 10;
    localparam int B_REN = 9;
    localparam int B_TEN = 8;
    localparam int B_PO = 6;
    localparam int B_PH = 5;
    localparam int B_HB = 4;
    // ==========================================================
    // event bits of status and mask registers
    localparam int I_TE = 0;
    localparam int I_RE = 1;
    localparam int I_PE = 2;
    localparam int I_BE = 3;
    localparam int I_WD = 4;
    // ==========================================================
    // reset values, write masks, counts
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hCF7F;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    localparam logic [4:0] IRQ_RST = 5'h00;
    localparam logic [3:0] GUARD_CYC = 4'h2;
    localparam logic [1:0] SYNC_RST = 2'h0;
    typedef enum {ST_IDLE, ST_RUN} sscs_state_t;
endpackage
`default_nettype wire

// ---- core/sscs_sync2.sv ----
// sscs_sync2: two-stage synchroniser for the serial clock and data pins
// assumes inputs are asynchronous to i_clk
`default_nettype none
module sscs_sync2
    import sscs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [1:0] i_d,
    output logic [1:0] o_q
);
    logic [1:0] meta_q;

    // ==========================================================
    // first stage feeds the second only
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= SYNC_RST;
            o_q <= SYNC_RST;
        end else if (i_ce) begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- core/sscs_top.sv ----
// sscs_top: control/status register and serial engine of a sync serial port
// assumes a classic wishbone master on i_core_clk; pins are asynchronous
//
// The implementer's own choice: the Wishbone interface to the registers.
`default_nettype none
module sscs_top
    import sscs_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_irq,
    input wire logic i_sclk,
    output logic o_sclk,
    output logic o_sclk_oe,
    input wire logic i_rx_data,
    output logic o_tx_data
);
    // ==========================================================
    // helpers
    function automatic logic [15:0] wmerge(input logic [15:0] o, input logic [15:0] n,
                                           input logic [3:0] s);
        wmerge = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
    endfunction

    function automatic logic [15:0] txalign(input logic [15:0] w, input logic [4:0] n,
                                            input logic m);
        txalign = m ? 16'(w << (5'h10 - n)) : w;
    endfunction

    function automatic logic outbit(input logic [15:0] s, input logic m);
        outbit = m ? s[15] : s[0];
    endfunction

    function automatic logic [3:0] sat(input logic [3:0] c);
        sat = (c >= GUARD_CYC) ? c : c + 4'h1;
    endfunction

    // ==========================================================
    // state
    logic [1:0] pin_s;
    logic [15:0] ctrl_q, ctrl_d, baud_q, baud_d, txb_q, txb_d, rxb_q, rxb_d;
    logic tx_full_q, tx_full_d, rx_full_q, rx_full_d;
    logic [4:0] isr_q, isr_d, imr_q, imr_d, ev;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d, irq_q, irq_d;
    sscs_state_t st_q, st_d;
    logic sclk_q, sclk_d, oe_q, oe_d, txd_q, txd_d;
    logic [15:0] div_q, div_d, tsh_q, tsh_d, rsh_q, rsh_d, rx_word;
    logic [5:0] edge_q, edge_d;
    logic [4:0] bits_q, bits_d;
    logic [18:0] per_q, per_d;
    logic per_vld_q, per_vld_d, sclk_prev_q, rxd_prev_q;
    logic [3:0] chg_q, chg_d, smp_q, smp_d;
    logic ev_start, ev_done;

    sscs_sync2 u_sync (
        .i_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_d({i_sclk, i_rx_data}),
        .o_q(pin_s)
    );

    // ==========================================================
    // decoded controls
    wire en = ctrl_q[B_EN];
    wire ms = ctrl_q[B_MS];
    wire cpol = ctrl_q[B_PO];
    wire cpha = ctrl_q[B_PH];
    wire msb = ctrl_q[B_HB];
    wire [4:0] len = {1'b0, ctrl_q[3:0]} + 5'h01;
    wire [18:0] hp = {3'h0, baud_q} + 19'h00001;
    wire busy = (st_q == ST_RUN);

    wire hit = i_wb_cyc && i_wb_stb;
    wire wr_now = hit && i_wb_we && ack_q;
    wire rd_rxb = hit && !i_wb_we && ack_q && (i_wb_adr == OFS_RXB);
    wire rd_ctrl = hit && !i_wb_we && !ack_q && (i_wb_adr == OFS_CTRL);

    // link edges: slave edges from the synchronised pin
    wire s_chg = pin_s[1] != sclk_prev_q;
    wire s_lead = !ms && s_chg && (pin_s[1] != cpol);
    wire s_trail = !ms && s_chg && (pin_s[1] == cpol);
    wire m_tog = busy && ms && (div_q == 16'h0000);
    wire lead = s_lead || (m_tog && sclk_q == cpol);
    wire trail = s_trail || (m_tog && sclk_q != cpol);
    // how a word starts in each role
    wire start = !busy && en && (ms ? tx_full_q : s_lead);
    wire run = busy || start;
    wire samp_e = run && (cpha ? lead : trail);
    wire shift_e = busy && (cpha ? trail : lead) && bits_q != 5'h00 && bits_q < len;
    wire rx_chg = pin_s[0] != rxd_prev_q;

    // ==========================================================
    // event decode; disabled checks never raise a flag
    always_comb begin
        ev = 5'h00;
        ev[I_TE] = ev_start && !tx_full_q && ctrl_q[B_TEN];
        ev[I_RE] = ev_done && rx_full_q && ctrl_q[B_REN];
        ev[I_PE] = run && ctrl_q[B_PEN] &&
                   ((samp_e && (rx_chg || chg_q < GUARD_CYC)) || (rx_chg && smp_q < GUARD_CYC));
        ev[I_BE] = s_lead && busy && per_vld_q && ctrl_q[B_BEN] &&
                   (per_q >= (hp << 2) || per_q <= hp);
        ev[I_WD] = ev_done;
    end

    // ==========================================================
    // register file and bus slave
    always_comb begin
        ctrl_d = ctrl_q;
        baud_d = baud_q;
        txb_d = txb_q;
        rxb_d = rxb_q;
        tx_full_d = tx_full_q;
        rx_full_d = rx_full_q;
        imr_d = imr_q;
        isr_d = isr_q;
        ack_d = hit && !ack_q;
        dat_d = 32'h0000_0000;
        if (hit && !ack_q && !i_wb_we) begin
            case (i_wb_adr)
                OFS_CTRL: dat_d = {16'h0000, en ? {1'b1, ms, 1'b0, busy, isr_q[I_BE], isr_q[I_PE],
                                   isr_q[I_RE], isr_q[I_TE], 4'h0, bits_q[3:0]} : ctrl_q};
                OFS_BAUD: dat_d = {16'h0000, baud_q};
                OFS_TXB: dat_d = {16'h0000, txb_q};
                OFS_RXB: dat_d = {16'h0000, rxb_q};
                OFS_ISR: dat_d = {27'h0000000, isr_q};
                OFS_IMR: dat_d = {27'h0000000, imr_q};
                default: dat_d = 32'h0000_0000;
            endcase
        end
        if (rd_rxb) begin
            rx_full_d = 1'b0;
        end
        if (ev_start) begin
            tx_full_d = 1'b0;
        end
        if (wr_now) begin
            case (i_wb_adr)
                OFS_CTRL: begin
                    // only the enable bit moves while operating
                    if (!en) begin
                        ctrl_d = wmerge(ctrl_q, i_wb_dat[15:0], i_wb_sel) & CTRL_WMASK;
                    end else if (i_wb_sel[1]) begin
                        ctrl_d[B_EN] = i_wb_dat[B_EN];
                    end
                end
                OFS_BAUD: baud_d = wmerge(baud_q, i_wb_dat[15:0], i_wb_sel);
                OFS_TXB: begin
                    txb_d = wmerge(txb_q, i_wb_dat[15:0], i_wb_sel);
                    tx_full_d = 1'b1;
                end
                OFS_ISR: begin
                    if (i_wb_sel[0]) begin
                        isr_d = isr_q & ~i_wb_dat[4:0];
                    end
                end
                OFS_IMR: begin
                    if (i_wb_sel[0]) begin
                        imr_d = i_wb_dat[4:0];
                    end
                end
                default: ;
            endcase
        end
        // a completed word always lands; set beats clear on every flag
        if (ev_done) begin
            rxb_d = rx_word;
            rx_full_d = 1'b1;
        end
        isr_d = isr_d | ev;
        irq_d = |(isr_d & imr_d);
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_q <= CTRL_RST;
            baud_q <= BAUD_RST;
            txb_q <= 16'h0000;
            rxb_q <= 16'h0000;
            tx_full_q <= 1'b0;
            rx_full_q <= 1'b0;
            isr_q <= IRQ_RST;
            imr_q <= IRQ_RST;
            dat_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (i_ce) begin
            ctrl_q <= ctrl_d;
            baud_q <= baud_d;
            txb_q <= txb_d;
            rxb_q <= rxb_d;
            tx_full_q <= tx_full_d;
            rx_full_q <= rx_full_d;
            isr_q <= isr_d;
            imr_q <= imr_d;
            dat_q <= dat_d;
            ack_q <= ack_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // serial engine
    always_comb begin
        st_d = st_q;
        sclk_d = sclk_q;
        div_d = div_q;
        edge_d = edge_q;
        bits_d = bits_q;
        tsh_d = tsh_q;
        rsh_d = rsh_q;
        per_d = (&per_q) ? per_q : per_q + 19'h00001;
        per_vld_d = per_vld_q;
        chg_d = rx_chg ? 4'h0 : sat(chg_q);
        smp_d = samp_e ? 4'h0 : sat(smp_q);
        ev_start = 1'b0;
        ev_done = 1'b0;
        rx_word = rsh_q;
        case (st_q)
            ST_IDLE: begin
                // clock rests at the polarity level
                sclk_d = cpol;
                tsh_d = txalign(txb_q, len, msb);
                rsh_d = 16'h0000;
                bits_d = 5'h00;
                per_vld_d = 1'b0;
                if (start) begin
                    st_d = ST_RUN;
                    ev_start = 1'b1;
                    div_d = baud_q;
                    edge_d = 6'h00;
                end
            end
            ST_RUN: begin
                // internal divider toggles the driven clock
                if (m_tog) begin
                    div_d = baud_q;
                    sclk_d = ~sclk_q;
                    edge_d = edge_q + 6'h01;
                    if (edge_q + 6'h01 == {len, 1'b0}) begin
                        st_d = ST_IDLE;
                    end
                end else if (ms) begin
                    div_d = div_q - 16'h0001;
                end
                if (shift_e) begin
                    tsh_d = msb ? {tsh_q[14:0], 1'b0} : {1'b0, tsh_q[15:1]};
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (s_lead) begin
            per_d = 19'h00001;
            per_vld_d = run;
        end
        // latch receive bit on the sampling edge
        if (samp_e) begin
            rsh_d = msb ? {rsh_d[14:0], pin_s[0]} : {pin_s[0], rsh_d[15:1]};
            bits_d = bits_q + 5'h01;
            if (bits_q + 5'h01 == len) begin
                ev_done = 1'b1;
                rx_word = msb ? rsh_d : 16'(rsh_d >> (5'h10 - len));
                // slave word ends on its last sample
                if (!ms) begin
                    st_d = ST_IDLE;
                end
            end
        end
        if (!en) begin
            st_d = ST_IDLE;
            sclk_d = cpol;
        end
        oe_d = en && ms;
        txd_d = outbit(tsh_d, msb);
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= ST_IDLE;
            sclk_q <= 1'b0;
            oe_q <= 1'b0;
            txd_q <= 1'b0;
            div_q <= 16'h0000;
            edge_q <= 6'h00;
            bits_q <= 5'h00;
            tsh_q <= 16'h0000;
            rsh_q <= 16'h0000;
            per_q <= 19'h00000;
            per_vld_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            rxd_prev_q <= 1'b0;
            chg_q <= GUARD_CYC;
            smp_q <= GUARD_CYC;
        end else if (i_ce) begin
            st_q <= st_d;
            sclk_q <= sclk_d;
            oe_q <= oe_d;
            txd_q <= txd_d;
            div_q <= div_d;
            edge_q <= edge_d;
            bits_q <= bits_d;
            tsh_q <= tsh_d;
            rsh_q <= rsh_d;
            per_q <= per_d;
            per_vld_q <= per_vld_d;
            sclk_prev_q <= pin_s[1];
            rxd_prev_q <= pin_s[0];
            chg_q <= chg_d;
            smp_q <= smp_d;
        end
    end

    assign o_wb_dat = dat_q;
    assign o_wb_ack = ack_q;
    assign o_irq = irq_q;
    assign o_sclk = sclk_q;
    assign o_sclk_oe = oe_q;
    assign o_tx_data = txd_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn || !i_ce);

    cfg_view_a: assert property (rd_ctrl && !en |=> o_wb_dat == {16'h0000, $past(ctrl_q)})
        else $error("config view wrong");
    busy_bit_a: assert property (rd_ctrl && en |=> o_wb_dat[12] == $past(busy))
        else $error("busy bit wrong");
    ms_view_a: assert property (rd_ctrl |=> o_wb_dat[14] == $past(ms) && o_wb_dat[31:16] == 16'h0000)
        else $error("master bit or upper bits wrong");
    slave_no_drive_a: assert property (!ms ##1 !ms |-> !o_sclk_oe)
        else $error("slave drives clock");
    master_clock_a: assert property (start && ms && baud_q == 16'h0007 |->
        ##8 o_sclk == $past(cpol, 8) ##1 o_sclk != $past(cpol, 9))
        else $error("master clock did not toggle");
    idle_level_a: assert property ($past(st_q == ST_IDLE) |-> o_sclk == $past(cpol))
        else $error("idle clock level wrong");
    rx_overrun_a: assert property (ev_done && rx_full_q && ctrl_q[B_REN] |=> isr_q[I_RE])
        else $error("overrun not flagged");
    rx_ignore_a: assert property (!ctrl_q[B_REN] |=> !$rose(isr_q[I_RE]))
        else $error("receive error while unchecked");
    tx_underrun_a: assert property (ev_start && !tx_full_q && ctrl_q[B_TEN] |=> isr_q[I_TE])
        else $error("underrun not flagged");
    baud_fast_a: assert property (s_lead && busy && per_vld_q && ctrl_q[B_BEN] && per_q <= hp |=> isr_q[I_BE])
        else $error("fast clock not flagged");
    baud_ignore_a: assert property (!ctrl_q[B_BEN] |=> !$rose(isr_q[I_BE]))
        else $error("baud error while unchecked");
    phase_guard_a: assert property (samp_e && ctrl_q[B_PEN] && chg_q < GUARD_CYC |=> isr_q[I_PE])
        else $error("phase error missed");
    lead_hold_a: assert property (busy && lead && !cpha && !trail |=> bits_q == $past(bits_q))
        else $error("sampled on wrong edge");

    master_word_c: cover property (ev_done && ms);
    slave_word_c: cover property (ev_done && !ms);
    overrun_c: cover property (ev[I_RE]);
    phase_err_c: cover property (ev[I_PE]);
endmodule
`default_nettype wire

// ---- tb/sscs_peer.sv ----
// sscs_peer: behavioural far-side device of the sync serial link
// assumes the bench resolves the shared clock pin and calls xfer
`default_nettype none
module sscs_peer (
    input wire logic i_pin,
    input wire logic i_dev_tx,
    output logic o_sclk,
    output logic o_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sclk = 1'b0;
        o_rx = 1'b0;
    end
    // ==========================================================
    // one 8-bit word, msb first; as master it clocks at 400 ns
    task automatic xfer(input logic mst, input logic pol, input logic pha, input logic glitch,
                        input logic [7:0] tx, output logic [7:0] rx);
        int s;
        logic smp;
        s = 0;
        rx = 8'h00;
        o_rx = tx[7];
        if (mst) begin
            o_sclk = pol;
            // off the core edge, so sampling never races
            #7;
        end
        for (int k = 1; k <= 16; k++) begin
            if (mst) begin
                #200 o_sclk = ~o_sclk;
            end else begin
                @(i_pin);
            end
            smp = (pha == 1'b0) ? (k % 2 == 0) : (k % 2 == 1);
            if (smp) begin
                rx = {rx[6:0], i_dev_tx};
                s++;
                if (glitch) o_rx = ~o_rx;
            end else if (s > 0 && s < 8) begin
                o_rx = tx[7 - s];
            end
        end
        // released data line shows no stale value
        #200 o_rx = ~o_rx;
    endtask
endmodule
`default_nettype wire

// ---- tb/sscs_top_tb_top.sv ----
// sscs_top_tb_top: register-level bench of the sync serial port
// assumes sscs_peer on the pins and a 20 MHz core clock
`default_nettype none
module sscs_top_tb_top
    import sscs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_core_clk, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we;
    logic [11:0] i_wb_adr;
    logic [3:0] i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, q, cfg;
    logic o_wb_ack, o_irq, o_sclk, o_sclk_oe, o_tx_data, peer_sclk, peer_rx;
    logic [7:0] prx, pv, dv;
    int n_fail = 0;
    int n_tests = 0;
    wire logic sclk_pin = o_sclk_oe ? o_sclk : peer_sclk;
    sscs_top sscs_top_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
        .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq),
        .i_sclk(sclk_pin), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe), .i_rx_data(peer_rx),
        .o_tx_data(o_tx_data));
    sscs_peer sscs_peer_i (.i_pin(sclk_pin), .i_dev_tx(o_tx_data), .o_sclk(peer_sclk), .o_rx(peer_rx));
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    // ==========================================================
    // bus and compare tasks
    task automatic stop_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_tests++;
        if ((got & m) !== (exp & m)) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        // start every request just after a core edge
        @(posedge i_core_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= a;
        i_wb_dat <= d;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 40);
        q = o_wb_dat;
        if (n >= 40) n_fail++;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        // registered pins settle before anyone looks
        repeat (2) @(posedge i_core_clk);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        wb(1'b0, a, 32'h0);
        chk(q, exp, m);
    endtask
    task automatic idle_wait();
        int n;
        n = 0;
        do begin
            wb(1'b0, OFS_CTRL, 32'h0);
            n++;
        end while (q[B_BSY] !== 1'b0 && n < 100);
        if (n >= 100) n_fail++;
    endtask
    task automatic reconf(input logic [31:0] baud, input logic [31:0] c);
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b1, OFS_BAUD, baud);
        wb(1'b1, OFS_CTRL, c);
        wb(1'b1, OFS_ISR, 32'h1F);
    endtask
    // ==========================================================
    // test sequence
    initial begin
        i_rstn = 1'b0;
        i_wb_cyc = 1'b0;
        i_wb_stb = 1'b0;
        i_wb_we = 1'b0;
        i_wb_adr = 12'h000;
        i_wb_sel = 4'hF;
        i_wb_dat = 32'h0;
        repeat (10) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        @(posedge i_core_clk);
        rc(OFS_CTRL, 32'h0, 32'hFFFFFFFF);
        wb(1'b1, OFS_CTRL, 32'hFFFF7FFF);
        rc(OFS_CTRL, 32'h00004F7F, 32'hFFFFFFFF);
        chk({31'h0, o_sclk}, 32'h1, 32'h1);
        rc(12'h3F0, 32'h0, 32'hFFFFFFFF);
        for (int m = 0; m < 4; m++) begin
            cfg = 32'hC017 | (32'(m) << 5);
            pv = 8'h3C + 8'(m);
            dv = 8'hA5 ^ 8'(m);
            reconf(32'h7, cfg);
            chk({31'h0, o_sclk_oe}, 32'h1, 32'h1);
            chk({31'h0, o_sclk}, {31'h0, cfg[B_PO]}, 32'h1);
            fork
                sscs_peer_i.xfer(1'b0, cfg[B_PO], cfg[B_PH], 1'b0, pv, prx);
                begin
                    wb(1'b1, OFS_TXB, {24'h0, dv});
                    rc(OFS_CTRL, 32'hD000, 32'hFFFFFFF0);
                end
            join
            idle_wait();
            rc(OFS_RXB, {24'h0, pv}, 32'hFFFFFFFF);
            chk({24'h0, prx}, {24'h0, dv}, 32'hFFFFFFFF);
        end
        reconf(32'h3, 32'h8817);
        chk({31'h0, o_sclk_oe}, 32'h0, 32'h1);
        wb(1'b1, OFS_TXB, 32'h96);
        sscs_peer_i.xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h69, prx);
        idle_wait();
        rc(OFS_CTRL, 32'h8000, 32'hFFFFFFF0);
        rc(OFS_RXB, 32'h69, 32'hFFFFFFFF);
        chk({24'h0, prx}, 32'h96, 32'hFFFFFFFF);
        reconf(32'h3, 32'h8317);
        wb(1'b1, OFS_IMR, 32'h0);
        wb(1'b1, OFS_TXB, 32'h11);
        // second word: buffer unread and not refilled
        repeat (2) begin
            sscs_peer_i.xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h22, prx);
            idle_wait();
        end
        rc(OFS_CTRL, 32'h8300, 32'hFFFFFFF0);
        rc(OFS_ISR, 32'h13, 32'hFFFFFFFF);
        chk({31'h0, o_irq}, 32'h0, 32'h1);
        wb(1'b1, OFS_IMR, 32'h2);
        chk({31'h0, o_irq}, 32'h1, 32'h1);
        wb(1'b1, OFS_ISR, 32'h2);
        chk({31'h0, o_irq}, 32'h0, 32'h1);
        rc(OFS_ISR, 32'h11, 32'hFFFFFFFF);
        // link clock four times slower, then four times faster than set
        for (int b = 0; b < 2; b++) begin
            reconf(32'(b * 15), 32'h8817);
            sscs_peer_i.xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h5A, prx);
            idle_wait();
            rc(OFS_CTRL, 32'h8800, 32'hFFFFFFF0);
        end
        reconf(32'h0, 32'h8417);
        sscs_peer_i.xfer(1'b1, 1'b0, 1'b0, 1'b1, 8'h5A, prx);
        idle_wait();
        rc(OFS_CTRL, 32'h8400, 32'hFFFFFFF0);
        stop_test();
    end
    initial begin
        #1000000;
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
